// [src/lrxa_map.vh]
// Register map, field positions, reset values and counts of the line receiver alarm block
`ifndef LRXA_MAP_VH
`define LRXA_MAP_VH

// Word-aligned byte offsets on the Wishbone bus
`define LRXA_OFS_STATUS 8'h00
`define LRXA_OFS_CLEAR 8'h04
`define LRXA_OFS_ENABLE 8'h08
`define LRXA_OFS_STATE 8'h0C
`define LRXA_OFS_CONTROL 8'h10

// Event bits shared by status, clear and enable
`define LRXA_EV_LOCK_SET 0
`define LRXA_EV_SIG_SET 1
`define LRXA_EV_PHASE_HIT 2
`define LRXA_EV_LOCK_OK 3
`define LRXA_EV_WIDTH 4

// Live state register fields
`define LRXA_ST_LOCK_ALARM 0
`define LRXA_ST_SIG_ALARM 1
`define LRXA_ST_FREQ_BAD 2
`define LRXA_ST_REACQ 3
`define LRXA_ST_EQ_BYPASS 4
`define LRXA_ST_THR_LO 5
`define LRXA_ST_THR_HI 6

// Control register fields and reset values
`define LRXA_CTL_DIG_LOS_EN 0
`define LRXA_CTL_RESET 1'b1
`define LRXA_EN_RESET 4'h0

// Alarm timing in recovered clock cycles
`define LRXA_MIN_ALARM_CYCLES 6'h20
`define LRXA_ZERO_RUN_LIMIT 8'hA0
`define LRXA_ONES_NEEDED 6'h08
`define LRXA_ONES_WINDOW 6'h20

// Frequency supervision: window in reference edges, tolerance is 0.5 percent of it
`define LRXA_REF_WINDOW 12'h400
`define LRXA_FREQ_TOL 12'h005

// Reacquisition after a phase hit
`define LRXA_RECOVER_US 2000
`define LRXA_CLK_MHZ 20

`endif

// [src/lrxa_freq_cmp.v]
// Frequency comparator of recovered clock edges against reference clock edges
`timescale 1ns/1ps
`include "lrxa_map.vh"

module lrxa_freq_cmp (
    input wire clock,
    input wire rstn,
    input wire ref_edge,
    input wire rec_edge,
    output reg freq_bad
);

reg [11:0] ref_cnt_reg;
reg [11:0] rec_cnt_reg;
wire window_end;
wire [11:0] diff;

assign window_end = ref_edge && (ref_cnt_reg == `LRXA_REF_WINDOW - 12'h001);
// Absolute difference between counted edges and the window length
assign diff = (rec_cnt_reg > `LRXA_REF_WINDOW) ? (rec_cnt_reg - `LRXA_REF_WINDOW)
            : (`LRXA_REF_WINDOW - rec_cnt_reg);

// Count both clocks over one reference window; verdict is refreshed once per window
always @(posedge clock)
begin
    if (!rstn)
    begin
        ref_cnt_reg <= 12'h000;
        rec_cnt_reg <= 12'h000;
        freq_bad <= 1'b1;
    end
    else
    begin
        if (window_end)
        begin
            ref_cnt_reg <= 12'h000;
            rec_cnt_reg <= {11'h000, rec_edge};
            freq_bad <= (diff > `LRXA_FREQ_TOL); // RULE_01
        end
        else
        begin
            if (ref_edge)
                ref_cnt_reg <= ref_cnt_reg + 12'h001;
            // Saturate so a runaway clock cannot wrap back into tolerance
            if (rec_edge && rec_cnt_reg != 12'hFFF)
                rec_cnt_reg <= rec_cnt_reg + 12'h001;
        end
    end
end

endmodule // lrxa_freq_cmp

// [src/lrxa_top.v]
// Alarm, dual-rail output and register logic of the coax line receiver digital side
// What this block does
// RULE_01 - Lock alarm when frequency off beyond 0.5%
// RULE_02 - Lock alarm when data locked 180 degrees off
// RULE_03 - Lock alarm holds until lock, minimum 32
// RULE_04 - Signal alarm is analog OR digital detector
// RULE_05 - Analog-set signal alarm lasts 32 cycles minimum
// RULE_06 - Digital alarm after 160 consecutive zeros
// RULE_07 - Release needs eight ones in 32 bits
// RULE_08 - Recovery continues whatever the signal alarm
// RULE_09 - Threshold select fixed before power-up, never changed
// RULE_10 - Rails change on rising recovered edge
// RULE_11 - Positive, negative, zero map onto two rails
// RULE_12 - Line to rails latency three recovered clocks
// RULE_13 - Test input low releases all digital outputs
// RULE_14 - Error-free output within 2 ms after hit
// RULE_15 - Detectors evaluate one retimed bit per cycle
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "lrxa_map.vh"

module lrxa_top #(
    parameter RECOVER_CYCLES = `LRXA_RECOVER_US * `LRXA_CLK_MHZ
) (
    input wire clock,
    input wire rstn,
    input wire recovered_clock_in,
    input wire reference_clock_in,
    input wire line_pos_in,
    input wire line_neg_in,
    input wire analog_los_in,
    input wire phase_flip_in,
    input wire equalizer_bypass,
    input wire [1:0] loss_threshold_select,
    input wire test_tristate_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output wire irq,
    output reg [1:0] threshold_code,
    output reg recovered_clock_out,
    output wire recovered_clock_oe,
    output reg positive_rail_data,
    output wire positive_rail_oe,
    output reg negative_rail_data,
    output wire negative_rail_oe,
    output wire lock_loss_alarm,
    output wire lock_loss_oe,
    output wire signal_loss_alarm,
    output wire signal_loss_oe
);

// Count of ones in the density window
function [5:0] ones32;
    input [31:0] v;
    integer i;
    begin
        ones32 = 6'h00;
        for (i = 0; i < 32; i = i + 1)
            ones32 = ones32 + {5'h00, v[i]};
    end
endfunction

reg [9:0] sync1_reg;
reg [9:0] sync2_reg;
reg rec_d_reg;
reg ref_d_reg;
reg phase_d_reg;
wire rec_edge;
wire ref_edge;
wire phase_hit;
wire freq_bad;
wire oe;
wire [1:0] thr_sync;

// Every line-side pin level passes two flops before use; Wishbone inputs and reset are used directly
always @(posedge clock)
begin
    if (!rstn)
    begin
        sync1_reg <= 10'h000;
        sync2_reg <= 10'h000;
    end
    else
    begin
        sync1_reg <= {loss_threshold_select, equalizer_bypass, test_tristate_n, phase_flip_in,
                      analog_los_in, line_neg_in, line_pos_in, reference_clock_in, recovered_clock_in};
        sync2_reg <= sync1_reg;
    end
end

assign thr_sync = sync2_reg[9:8];
assign oe = sync2_reg[6];

// Edge finders look only at the second synchroniser stage
always @(posedge clock)
begin
    if (!rstn)
    begin
        rec_d_reg <= 1'b0;
        ref_d_reg <= 1'b0;
        phase_d_reg <= 1'b0;
    end
    else
    begin
        rec_d_reg <= sync2_reg[0];
        ref_d_reg <= sync2_reg[1];
        phase_d_reg <= sync2_reg[5];
    end
end

assign rec_edge = sync2_reg[0] && !rec_d_reg;
assign ref_edge = sync2_reg[1] && !ref_d_reg;
assign phase_hit = sync2_reg[5] && !phase_d_reg;

lrxa_freq_cmp u_freq (
    .clock(clock),
    .rstn(rstn),
    .ref_edge(ref_edge),
    .rec_edge(rec_edge),
    .freq_bad(freq_bad)
);

// Threshold strap is caught once the synchroniser holds a real pin value; later pin moves are ignored
// Waiting two edges avoids latching the reset contents of the synchroniser instead of the strap
reg thr_taken_reg;
reg [1:0] thr_settle_reg;
always @(posedge clock)
begin
    if (!rstn)
    begin
        thr_taken_reg <= 1'b0;
        thr_settle_reg <= 2'h0;
        threshold_code <= 2'h0;
    end
    else if (thr_settle_reg != 2'h2)
        thr_settle_reg <= thr_settle_reg + 2'h1;
    else if (!thr_taken_reg)
    begin
        thr_taken_reg <= 1'b1; // RULE_09
        threshold_code <= thr_sync;
    end
end

// Reacquisition timer after a phase hit; rails are squelched so no bad bits leave
reg [15:0] reacq_cnt_reg;
wire reacq;
assign reacq = (reacq_cnt_reg != 16'h0000);
always @(posedge clock)
begin
    if (!rstn)
        reacq_cnt_reg <= 16'h0000;
    else if (phase_hit)
        reacq_cnt_reg <= RECOVER_CYCLES[15:0]; // RULE_14
    else if (reacq)
        reacq_cnt_reg <= reacq_cnt_reg - 16'h0001;
end

// Retiming pipeline, three recovered clocks deep, never gated by the signal alarm
reg [1:0] stage1_reg;
reg [1:0] stage2_reg;
always @(posedge clock)
begin
    if (!rstn)
    begin
        stage1_reg <= 2'h0;
        stage2_reg <= 2'h0;
        positive_rail_data <= 1'b0;
        negative_rail_data <= 1'b0;
        recovered_clock_out <= 1'b0;
    end
    else
    begin
        recovered_clock_out <= sync2_reg[0];
        if (rec_edge) // RULE_08 RULE_10
        begin
            stage1_reg <= sync2_reg[3:2]; // RULE_12
            stage2_reg <= stage1_reg;
            // Both rails high on a line fault is treated as a zero
            positive_rail_data <= stage2_reg[0] && !stage2_reg[1] && !reacq; // RULE_11
            negative_rail_data <= stage2_reg[1] && !stage2_reg[0] && !reacq; // RULE_11
        end
    end
end

// Lock alarm with a minimum width counted in recovered clocks
reg lock_alarm_reg;
reg [5:0] lock_min_reg;
always @(posedge clock)
begin
    if (!rstn)
    begin
        lock_alarm_reg <= 1'b1;
        lock_min_reg <= 6'h00;
    end
    else if (freq_bad || phase_hit) // RULE_01 RULE_02
    begin
        if (!lock_alarm_reg)
            lock_min_reg <= 6'h00;
        lock_alarm_reg <= 1'b1;
    end
    else if (lock_alarm_reg)
    begin
        if (lock_min_reg == `LRXA_MIN_ALARM_CYCLES)
            lock_alarm_reg <= 1'b0; // RULE_03
        else if (rec_edge)
            lock_min_reg <= lock_min_reg + 6'h01; // RULE_03
    end
end

// Analog detector stretched so a short loss is still seen
reg [5:0] ana_hold_reg;
wire ana_los;
assign ana_los = sync2_reg[4] || (ana_hold_reg != 6'h00);
always @(posedge clock)
begin
    if (!rstn)
        ana_hold_reg <= 6'h00;
    else if (sync2_reg[4])
        ana_hold_reg <= `LRXA_MIN_ALARM_CYCLES; // RULE_05
    else if (rec_edge && ana_hold_reg != 6'h00)
        ana_hold_reg <= ana_hold_reg - 6'h01;
end

// Digital ones-density detector, one retimed bit per recovered clock
reg ctl_dig_en_reg;
reg dig_los_reg;
reg [7:0] zero_run_reg;
reg [31:0] window_reg;
reg [5:0] fill_reg;
wire bit_one;
assign bit_one = stage1_reg[0] || stage1_reg[1];
always @(posedge clock)
begin
    if (!rstn || !ctl_dig_en_reg)
    begin
        dig_los_reg <= 1'b0;
        zero_run_reg <= 8'h00;
        window_reg <= 32'h0000_0000;
        fill_reg <= 6'h00;
    end
    else if (rec_edge) // RULE_15
    begin
        window_reg <= {window_reg[30:0], bit_one};
        if (bit_one)
            zero_run_reg <= 8'h00;
        else if (zero_run_reg != 8'hFF)
            zero_run_reg <= zero_run_reg + 8'h01;
        if (!dig_los_reg && !bit_one && zero_run_reg == `LRXA_ZERO_RUN_LIMIT - 8'h01)
        begin
            dig_los_reg <= 1'b1; // RULE_06
            fill_reg <= 6'h00;
        end
        else if (dig_los_reg)
        begin
            if (fill_reg != `LRXA_ONES_WINDOW)
                fill_reg <= fill_reg + 6'h01;
            // A full fresh window keeps the alarm at least 32 cycles wide
            if (fill_reg == `LRXA_ONES_WINDOW && ones32(window_reg) >= `LRXA_ONES_NEEDED)
                dig_los_reg <= 1'b0; // RULE_07
        end
    end
end

wire sig_alarm;
assign sig_alarm = ana_los || dig_los_reg; // RULE_04

// Pins are released while the test input is held low
assign recovered_clock_oe = oe; // RULE_13
assign positive_rail_oe = oe; // RULE_13
assign negative_rail_oe = oe; // RULE_13
assign lock_loss_oe = oe; // RULE_13
assign signal_loss_oe = oe; // RULE_13
assign lock_loss_alarm = lock_alarm_reg;
assign signal_loss_alarm = sig_alarm;

// Event detection for the interrupt status
reg lock_q_reg;
reg sig_q_reg;
reg [3:0] status_reg;
reg [3:0] enable_reg;
wire [3:0] events;
wire wr;
wire [3:0] clr;
always @(posedge clock)
begin
    if (!rstn)
    begin
        lock_q_reg <= 1'b1;
        sig_q_reg <= 1'b0;
    end
    else
    begin
        lock_q_reg <= lock_alarm_reg;
        sig_q_reg <= sig_alarm;
    end
end

assign events = {lock_q_reg && !lock_alarm_reg, phase_hit, sig_alarm && !sig_q_reg,
                 lock_alarm_reg && !lock_q_reg};
assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
assign clr = (wr && wb_adr_i == `LRXA_OFS_CLEAR) ? wb_dat_i[3:0] : 4'h0;
assign irq = |(status_reg & enable_reg);

// Sticky status: a new event beats a clear in the same cycle
always @(posedge clock)
begin
    if (!rstn)
        status_reg <= 4'h0;
    else
        status_reg <= (status_reg & ~clr) | events;
end

// Wishbone slave, answers one cycle after the strobe; unmapped reads give zero
always @(posedge clock)
begin
    if (!rstn)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
        enable_reg <= `LRXA_EN_RESET;
        ctl_dig_en_reg <= `LRXA_CTL_RESET;
    end
    else
    begin
        wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        if (wr && wb_adr_i == `LRXA_OFS_ENABLE)
            enable_reg <= wb_dat_i[3:0];
        if (wr && wb_adr_i == `LRXA_OFS_CONTROL)
            ctl_dig_en_reg <= wb_dat_i[`LRXA_CTL_DIG_LOS_EN];
        case (wb_adr_i)
            `LRXA_OFS_STATUS: wb_dat_o <= {28'h000_0000, status_reg};
            `LRXA_OFS_ENABLE: wb_dat_o <= {28'h000_0000, enable_reg};
            `LRXA_OFS_STATE: wb_dat_o <= {25'h000_0000, threshold_code, sync2_reg[7], reacq,
                                          freq_bad, sig_alarm, lock_alarm_reg};
            `LRXA_OFS_CONTROL: wb_dat_o <= {31'h0000_0000, ctl_dig_en_reg};
            default: wb_dat_o <= 32'h0000_0000;
        endcase
    end
end

endmodule // lrxa_top

// [tb/lrxa_monitor.sv]
// Port checker of alarm widths, rail timing and tristate control
`timescale 1ns/1ps
module lrxa_monitor (
    input wire clock,
    input wire rstn,
    input wire analog_los_in,
    input wire phase_flip_in,
    input wire test_tristate_n,
    input wire recovered_clock_out,
    input wire recovered_clock_oe,
    input wire positive_rail_data,
    input wire positive_rail_oe,
    input wire negative_rail_data,
    input wire negative_rail_oe,
    input wire lock_loss_alarm,
    input wire lock_loss_oe,
    input wire signal_loss_alarm,
    input wire signal_loss_oe
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    logic [9:0] lk_cnt_reg;
    logic [9:0] sg_cnt_reg;
    wire [4:0] oe5 = {recovered_clock_oe, positive_rail_oe, negative_rail_oe, lock_loss_oe, signal_loss_oe};
    // Alarm high time in cycles; saturates so a long alarm never wraps to a short one
    always @(posedge clock)
    begin
        lk_cnt_reg <= (!rstn || !lock_loss_alarm) ? 10'h000 : lk_cnt_reg + {9'h000, lk_cnt_reg != 10'h3ff};
        sg_cnt_reg <= (!rstn || !signal_loss_alarm) ? 10'h000 : sg_cnt_reg + {9'h000, sg_cnt_reg != 10'h3ff};
    end
    lock_min_a: assert property ($fell(lock_loss_alarm) |-> lk_cnt_reg >= 10'h0f0)
        else $error("lock alarm pulse too short");
    sig_min_a: assert property ($fell(signal_loss_alarm) |-> sg_cnt_reg >= 10'h0f0)
        else $error("signal alarm pulse too short");
    sig_or_a: assert property (analog_los_in [*4] |-> signal_loss_alarm)
        else $error("analog loss missing on signal alarm");
    phase_a: assert property ($rose(phase_flip_in) |-> ##[1:6] lock_loss_alarm)
        else $error("phase hit without lock alarm");
    rail_edge_a: assert property (($changed(positive_rail_data) || $changed(negative_rail_data))
        && !lock_loss_alarm && !$past(lock_loss_alarm) |-> $rose(recovered_clock_out))
        else $error("rail moved off the recovered rising edge");
    rails_excl_a: assert property (!(positive_rail_data && negative_rail_data))
        else $error("both rails high");
    oe_off_a: assert property ((!test_tristate_n) [*3] |-> oe5 == 5'h00)
        else $error("output driven in test mode");
    oe_on_a: assert property ((test_tristate_n && rstn) [*4] |-> oe5 == 5'h1f)
        else $error("output released in normal mode");
endmodule // lrxa_monitor

bind lrxa_top lrxa_monitor u_lrxa_monitor (.clock(clock), .rstn(rstn), .analog_los_in(analog_los_in),
    .phase_flip_in(phase_flip_in), .test_tristate_n(test_tristate_n), .recovered_clock_out(recovered_clock_out),
    .recovered_clock_oe(recovered_clock_oe), .positive_rail_data(positive_rail_data),
    .positive_rail_oe(positive_rail_oe), .negative_rail_data(negative_rail_data),
    .negative_rail_oe(negative_rail_oe), .lock_loss_alarm(lock_loss_alarm), .lock_loss_oe(lock_loss_oe),
    .signal_loss_alarm(signal_loss_alarm), .signal_loss_oe(signal_loss_oe));

// [tb/lrxa_framer.sv]
// Downstream framer model counting marks on each rail
`timescale 1ns/1ps
module lrxa_framer (
    input wire rclk,
    input wire pos,
    input wire neg,
    input wire oe,
    input wire clr,
    output logic [15:0] n_pos,
    output logic [15:0] n_neg
);
    // Samples mid-bit on the falling edge; a released rail counts nothing
    always @(negedge rclk)
    begin
        n_pos <= clr ? 16'h0000 : n_pos + {15'h0000, oe && pos};
        n_neg <= clr ? 16'h0000 : n_neg + {15'h0000, oe && neg};
    end
endmodule // lrxa_framer

// [tb/tb_line_rx_alarms_dual_rail_out.sv]
// Self-checking bench of the line receiver alarms and dual-rail outputs
`timescale 1ns/1ps
`include "lrxa_map.vh"
module tb_line_rx_alarms_dual_rail_out;
    logic clock = 1'h0, rstn = 1'h0, rclk = 1'h0, refc = 1'h0, line_pos_in = 1'h0, line_neg_in = 1'h0;
    logic analog_los_in = 1'h0, phase_flip_in = 1'h0, test_tristate_n = 1'h1, fclr = 1'h1;
    logic equalizer_bypass = 1'h1;
    logic [1:0] loss_threshold_select = 2'h2;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0000_0000, rd;
    wire [31:0] wb_dat_o;
    wire [1:0] threshold_code;
    wire wb_ack_o, irq, recovered_clock_out, recovered_clock_oe, positive_rail_data, positive_rail_oe;
    wire negative_rail_data, negative_rail_oe, lock_loss_alarm, lock_loss_oe, signal_loss_alarm, signal_loss_oe;
    wire [15:0] n_pos, n_neg;
    logic [1:0] mode = 2'h1;
    integer n_errors = 0, comparisons = 0;
    real rh = 200.0;
    // System clock, recovered clock of unrelated phase, reference clock
    always #25 clock = ~clock;
    initial
    begin
        #7;
        forever #200 rclk = ~rclk;
    end
    always #(rh) refc = ~refc;
    // Line bits change mid-bit so each recovered rising edge sees them settled
    always @(negedge rclk)
    begin
        line_pos_in <= mode[0];
        line_neg_in <= mode == 2'h2;
        if (mode == 2'h3)
            mode <= 2'h0;
    end
    lrxa_top #(.RECOVER_CYCLES(200)) u_lrxa_top (.clock(clock), .rstn(rstn), .recovered_clock_in(rclk),
        .reference_clock_in(refc), .line_pos_in(line_pos_in), .line_neg_in(line_neg_in),
        .analog_los_in(analog_los_in), .phase_flip_in(phase_flip_in), .equalizer_bypass(equalizer_bypass),
        .loss_threshold_select(loss_threshold_select), .test_tristate_n(test_tristate_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .threshold_code(threshold_code),
        .recovered_clock_out(recovered_clock_out), .recovered_clock_oe(recovered_clock_oe),
        .positive_rail_data(positive_rail_data), .positive_rail_oe(positive_rail_oe),
        .negative_rail_data(negative_rail_data), .negative_rail_oe(negative_rail_oe),
        .lock_loss_alarm(lock_loss_alarm), .lock_loss_oe(lock_loss_oe), .signal_loss_alarm(signal_loss_alarm),
        .signal_loss_oe(signal_loss_oe));
    lrxa_framer u_lrxa_framer (.rclk(recovered_clock_out), .pos(positive_rail_data), .neg(negative_rail_data),
        .oe(positive_rail_oe), .clr(fclr), .n_pos(n_pos), .n_neg(n_neg));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            comparisons++;
            if (got !== exp)
            begin
                n_errors++;
                $display("mismatch at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("errors %0d comparisons %0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // Classic single cycle, held until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer i;
        begin
            @(posedge clock);
            wb_cyc_i <= 1'h1;
            wb_stb_i <= 1'h1;
            wb_we_i <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            for (i = 0; i < 20 && wb_ack_o !== 1'h1; i++)
                @(posedge clock);
            rd = wb_dat_o;
            wb_cyc_i <= 1'h0;
            wb_stb_i <= 1'h0;
            chk(32'(i < 20), 32'h1);
            if (i == 20)
                end_sim;
        end
    endtask
    // Bounded wait for the signal alarm (s=1) or lock alarm (s=0) to reach v
    task wl(input logic s, input logic v, input integer lim);
        integer i;
        begin
            for (i = 0; i < lim && (s ? signal_loss_alarm : lock_loss_alarm) !== v; i++)
                @(posedge clock);
            chk(32'(i < lim), 32'h1);
            if (i == lim)
                end_sim;
        end
    endtask
    // Framer mark counts over n recovered periods
    task cnt(input integer n);
        begin
            fclr = 1'h1;
            repeat (2) @(negedge recovered_clock_out);
            #1 fclr = 1'h0;
            repeat (n) @(negedge recovered_clock_out);
            #1;
        end
    endtask
    task t_reg;
        begin
            wl(1'h0, 1'h0, 20000);
            wb(1'h0, `LRXA_OFS_ENABLE, 32'h0);
            chk(rd, 32'h0000_0000);
            wb(1'h0, `LRXA_OFS_CONTROL, 32'h0);
            chk(rd, 32'h0000_0001);
            wb(1'h0, 8'h20, 32'h0);
            chk(rd, 32'h0000_0000);
            wb(1'h0, `LRXA_OFS_STATE, 32'h0);
            chk(rd & 32'h0000_0073, 32'h0000_0050);
            chk({30'h0000_0000, threshold_code}, 32'h0000_0002);
            wb(1'h1, `LRXA_OFS_CONTROL, 32'h0000_0000);
            wb(1'h0, `LRXA_OFS_CONTROL, 32'h0);
            chk(rd, 32'h0000_0000);
            wb(1'h1, `LRXA_OFS_CONTROL, 32'h0000_0001);
            wb(1'h1, `LRXA_OFS_ENABLE, 32'h0000_0008);
            chk(32'(irq), 32'h1);
            wb(1'h1, `LRXA_OFS_CLEAR, 32'h0000_000f);
            chk(32'(irq), 32'h0);
            wb(1'h1, `LRXA_OFS_ENABLE, 32'h0);
            $display("register test done");
        end
    endtask
    task t_lat;
        integer i;
        begin
            mode = 2'h0;
            repeat (4) @(posedge rclk);
            mode = 2'h3;
            @(negedge rclk);
            #1;
            for (i = 1; i < 8; i++)
            begin
                @(posedge recovered_clock_out);
                #1;
                if (positive_rail_data === 1'h1)
                    break;
            end
            chk(i, 3);
            chk(32'(negative_rail_data), 32'h0);
            $display("latency test done");
        end
    endtask
    task t_dlos;
        begin
            repeat (120) @(posedge rclk);
            chk(32'(signal_loss_alarm), 32'h0);
            wl(1'h1, 1'h1, 800);
            wb(1'h0, `LRXA_OFS_STATUS, 32'h0);
            chk(rd & 32'h0000_0002, 32'h0000_0002);
            chk(32'(irq), 32'h0);
            mode = 2'h1;
            wl(1'h1, 1'h0, 800);
            $display("digital loss test done");
        end
    endtask
    task t_alos;
        begin
            mode = 2'h2;
            repeat (4) @(posedge rclk);
            @(posedge clock);
            analog_los_in <= 1'h1;
            repeat (8) @(posedge clock);
            analog_los_in <= 1'h0;
            cnt(20);
            chk(32'(signal_loss_alarm), 32'h1);
            chk(32'(n_neg > 16'h0000), 32'h1);
            chk({16'h0000, n_pos}, 32'h0);
            wl(1'h1, 1'h0, 800);
            $display("analog loss test done");
        end
    endtask
    task t_tst;
        begin
            @(posedge clock);
            test_tristate_n <= 1'h0;
            repeat (4) @(posedge clock);
            chk(32'(positive_rail_oe || lock_loss_oe || signal_loss_oe), 32'h0);
            test_tristate_n <= 1'h1;
            repeat (4) @(posedge clock);
            chk(32'(negative_rail_oe && recovered_clock_oe), 32'h1);
            $display("tristate test done");
        end
    endtask
    task t_phase;
        begin
            @(posedge clock);
            phase_flip_in <= 1'h1;
            wl(1'h0, 1'h1, 10);
            phase_flip_in <= 1'h0;
            wb(1'h0, `LRXA_OFS_STATUS, 32'h0);
            chk(rd & 32'h0000_0004, 32'h0000_0004);
            repeat (300) @(posedge clock);
            cnt(16);
            chk(32'(n_neg > 16'h0000), 32'h1);
            wl(1'h0, 1'h0, 800);
            rh = 202.0;
            wl(1'h0, 1'h1, 25000);
            rh = 200.0;
            wl(1'h0, 1'h0, 25000);
            $display("phase and frequency test done");
        end
    endtask
    // Watchdog: a stalled recovered clock must still end the run with a failure
    initial
    begin
        repeat (90000) @(posedge clock);
        chk(32'h0000_0000, 32'h0000_0001);
        end_sim;
    end
    // Main sequence after ten reset cycles
    initial
    begin
        repeat (10) @(posedge clock);
        rstn <= 1'h1;
        t_reg;
        t_lat;
        t_dlos;
        t_alos;
        t_tst;
        t_phase;
        end_sim;
    end
endmodule // tb_line_rx_alarms_dual_rail_out
